// >>> logic/drive_ctrl_pkg.sv
// shared constants and types for the serial drive control block
package drive_ctrl_pkg;
  // register indices on the plain register port
  localparam logic [3:0] reg_ctrl   = 4'h0;
  localparam logic [3:0] reg_cmd    = 4'h1;
  localparam logic [3:0] reg_status = 4'h2;
  localparam logic [3:0] reg_event  = 4'h3;
  localparam logic [3:0] reg_mask   = 4'h4;
  localparam logic [3:0] reg_resp   = 4'h5;
  localparam logic [3:0] reg_index  = 4'h6;
  // ctrl register fields
  localparam int ctrl_head_lo  = 0;
  localparam int ctrl_drive_lo = 4;
  localparam int ctrl_wr_bit   = 8;
  localparam int ctrl_rd_bit   = 9;
  localparam int ctrl_rsp_lo   = 10;
  // event bit positions
  localparam int ev_fault   = 0;
  localparam int ev_index   = 1;
  localparam int ev_ready   = 2;
  localparam int ev_cmd     = 3;
  localparam int ev_rsp     = 4;
  localparam int ev_parity  = 5;
  localparam int ev_count   = 6;
  localparam int cmd_bits   = 16;
  localparam int rsp_max    = 16;
  // pin outputs toward the drive cable
  typedef struct packed {
    logic [3:0] head_sel;
    logic [2:0] drive_sel;
    logic       write_gate;
    logic       read_gate;
    logic       transfer_request;
    logic       command_out;
  } drive_pins_t;
endpackage : drive_ctrl_pkg

// >>> logic/pin_sync.sv
// two flip-flop synchroniser for a group of cable inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int width = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // pins in, synchronised out
  input  wire logic [width-1:0] pin_in,
  output logic      [width-1:0] pin_sync_out
);
  logic [width-1:0] meta_ff;
  logic [width-1:0] sync_ff;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end
  assign pin_sync_out = sync_ff;
endmodule : pin_sync

// >>> logic/serial_handshake.sv
// four-phase bit shifter for command out and config/status in
`timescale 1ns/1ps
module serial_handshake
  import drive_ctrl_pkg::*;
#(
  parameter int width = 16
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // request
  input  wire logic             start,
  input  wire logic             dir_in,
  input  wire logic [4:0]       rsp_len,
  input  wire logic [width-1:0] cmd_word,
  // synchronised drive side
  input  wire logic             ack_s,
  input  wire logic             data_in_s,
  // drive side outputs
  output logic                  req_out,
  output logic                  data_out,
  // result
  output logic                  busy,
  output logic                  done,
  output logic                  parity_err,
  output logic      [width-1:0] rsp_word
);
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_req  = 2'b01,
    st_wait = 2'b10
  } hs_state_t;
  hs_state_t        state_ff;
  logic [width:0]   shift_ff;
  logic [4:0]       cnt_ff;
  logic [4:0]       total_ff;
  logic             dir_ff;
  logic             req_ff;
  logic             done_ff;
  logic             perr_ff;
  logic [width-1:0] rsp_ff;
  logic             par_ff;
  wire  last_bit   = (cnt_ff == total_ff);
  // odd parity over data bits
  wire  cmd_parity = ~^cmd_word;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= st_idle;
      shift_ff <= '0;
      cnt_ff   <= '0;
      total_ff <= '0;
      dir_ff   <= 1'b0;
      req_ff   <= 1'b0;
      done_ff  <= 1'b0;
      perr_ff  <= 1'b0;
      rsp_ff   <= '0;
      par_ff   <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      unique case (state_ff)
        st_idle:
        begin
          if (start && !ack_s)
          begin
            dir_ff   <= dir_in;
            shift_ff <= {cmd_parity, cmd_word}; // [RULE_10]
            total_ff <= dir_in ? rsp_len : 5'(cmd_bits);
            cnt_ff   <= '0;
            par_ff   <= 1'b1;
            rsp_ff   <= '0;
            req_ff   <= 1'b1;
            state_ff <= st_req;
          end
        end
        st_req:
        begin
          // drop request once the drive acknowledges the bit
          if (ack_s)
          begin
            req_ff <= 1'b0; // [RULE_13]
            if (dir_ff && !last_bit)
            begin
              rsp_ff <= {data_in_s, rsp_ff[width-1:1]};
              par_ff <= par_ff ^ data_in_s;
            end
            if (dir_ff && last_bit)
              perr_ff <= (par_ff ^ data_in_s) != 1'b0; // [RULE_11]
            state_ff <= st_wait;
          end
        end
        st_wait:
        begin
          // next bit only after acknowledge falls
          if (!ack_s)
          begin
            if (last_bit)
            begin
              done_ff  <= 1'b1;
              state_ff <= st_idle;
            end
            else
            begin
              cnt_ff   <= cnt_ff + 5'd1;
              shift_ff <= {1'b0, shift_ff[width:1]};
              req_ff   <= 1'b1; // [RULE_12]
              state_ff <= st_req;
            end
          end
        end
        default:
          state_ff <= st_idle;
      endcase
    end
  end
  assign req_out    = req_ff;
  assign data_out   = shift_ff[0] & ~dir_ff;
  assign busy       = (state_ff != st_idle);
  assign done       = done_ff;
  assign parity_err = perr_ff;
  assign rsp_word   = rsp_ff;
endmodule : serial_handshake

// >>> logic/drive_ctrl.sv
// serial drive control: selects, gates, status and serial transfers
// Behaviour
// RULE_01: drives are controlled only by the serial control protocol with handshaken bits; the code also drives select and gate lines in parallel.
// RULE_02: all outputs go to every drive, so the drive-select code names who responds.
// RULE_03: four binary head-select outputs choose one of 16 heads.
// RULE_04: three drive-select outputs carry an encoded drive number, not one-hot lines.
// RULE_05: write gate is high only while writing and falls as soon as fault attention is seen.
// RULE_06: read gate is high only while a read is wanted.
// RULE_07: the attention input is treated as a drive fault.
// RULE_08: index pulses mark track start and count revolutions for retry timeouts.
// RULE_09: drive ready decides whether the drive may be operated.
// RULE_10: a command goes out as 16 bits then one parity bit.
// RULE_11: config/status comes back serially ending with a parity bit.
// RULE_12: every serial bit is paced by transfer request and transfer acknowledge.
// RULE_13: each bit is a four-phase exchange of request and acknowledge.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module drive_ctrl
  import drive_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  // register port
  input  wire logic [3:0]                 reg_addr,
  input  wire logic [15:0]                reg_wdata,
  input  wire logic                       reg_write,
  input  wire logic                       reg_read,
  output logic      [15:0]                reg_rdata,
  // interrupt
  output logic                            irq,
  // drive control cable outputs
  output logic                            head_sel_bit0,
  output logic                            head_sel_bit1,
  output logic                            head_sel_bit2,
  output logic                            head_sel_bit3,
  output logic                            drive_sel_code_bit1,
  output logic                            drive_sel_code_bit2,
  output logic                            drive_sel_code_bit3,
  output logic                            write_gate,
  output logic                            read_gate,
  output logic                            transfer_request,
  output logic                            command_out,
  // drive control cable inputs
  input  wire logic                       config_status_serial_in,
  input  wire logic                       transfer_acknowledge,
  input  wire logic                       drive_fault_attention,
  input  wire logic                       drive_ready_in,
  input  wire logic                       index_pulse
);
  import drive_ctrl_pkg::*;

  logic [1:0] rst_sync_ff;
  wire        rst_n = rst_sync_ff[1];
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  // cable inputs are asynchronous to our clock
  logic [4:0] pins_s;
  pin_sync #(
    .width (5)
  ) u_sync (
    .clock        (clock),
    .rst_n        (rst_n),
    .pin_in       ({index_pulse, drive_ready_in, drive_fault_attention,
                    transfer_acknowledge, config_status_serial_in}),
    .pin_sync_out (pins_s)
  );
  wire csd_s   = pins_s[0];
  wire ack_s   = pins_s[1];
  wire fault_s = pins_s[2]; // [RULE_07]
  wire ready_s = pins_s[3]; // [RULE_09]
  wire index_s = pins_s[4];

  // registers
  logic [15:0]         ctrl_ff;
  logic [15:0]         cmd_ff;
  logic [ev_count-1:0] event_ff;
  logic [ev_count-1:0] mask_ff;
  logic [15:0]         rdata_ff;
  logic [15:0]         rev_cnt_ff;
  logic                index_d_ff;
  logic                ready_d_ff;
  logic                fault_d_ff;
  logic                busy_d_ff;
  logic                start_ff;
  logic                dir_ff;

  // register decode
  wire wr_ctrl   = reg_write && (reg_addr == reg_ctrl);
  wire wr_cmd    = reg_write && (reg_addr == reg_cmd);
  wire wr_mask   = reg_write && (reg_addr == reg_mask);
  wire wr_index  = reg_write && (reg_addr == reg_index);
  wire rd_event  = reg_read  && (reg_addr == reg_event);

  // serial engine
  logic        hs_busy;
  logic        hs_done;
  logic        hs_perr;
  logic [15:0] hs_rsp;
  logic        hs_req;
  logic        hs_data;
  serial_handshake #(
    .width (cmd_bits)
  ) u_serial (
    .clock      (clock),
    .rst_n      (rst_n),
    .start      (start_ff),
    .dir_in     (dir_ff),
    .rsp_len    (ctrl_ff[ctrl_rsp_lo +: 5]),
    .cmd_word   (cmd_ff),
    .ack_s      (ack_s),
    .data_in_s  (csd_s),
    .req_out    (hs_req),
    .data_out   (hs_data),
    .busy       (hs_busy),
    .done       (hs_done),
    .parity_err (hs_perr),
    .rsp_word   (hs_rsp)
  );

  // a write to the command register starts an outgoing command when idle and ready; a write to
  // the index register with bit 0 set (idle and ready) starts a config/status read instead
  wire start_cmd = wr_cmd && !hs_busy && ready_s; // [RULE_09]
  wire start_rsp = wr_index && reg_wdata[0] && !hs_busy && ready_s;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_ff   <= '0;
      start_ff <= 1'b0;
      dir_ff   <= 1'b0;
    end
    else
    begin
      start_ff <= start_cmd || start_rsp; // [RULE_01]
      if (start_cmd)
        cmd_ff <= reg_wdata;
      if (start_cmd || start_rsp)
        dir_ff <= start_rsp;
    end
  end

  // control register; write gate bit is cleared by hardware on fault
  wire fault_rise = fault_s && !fault_d_ff;
  logic [15:0] nxt_ctrl;
  assign nxt_ctrl = wr_ctrl ? reg_wdata : ctrl_ff;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_ff <= '0;
    else
    begin
      ctrl_ff <= nxt_ctrl;
      if (fault_s)
        ctrl_ff[ctrl_wr_bit] <= 1'b0; // [RULE_05]
    end
  end

  // revolution counter for retry timeouts; cleared by any index write
  wire index_rise = index_s && !index_d_ff;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rev_cnt_ff <= '0;
      index_d_ff <= 1'b0;
      ready_d_ff <= 1'b0;
      fault_d_ff <= 1'b0;
      busy_d_ff  <= 1'b0;
    end
    else
    begin
      index_d_ff <= index_s;
      ready_d_ff <= ready_s;
      fault_d_ff <= fault_s;
      busy_d_ff  <= hs_busy;
      if (wr_index)
        rev_cnt_ff <= '0;
      else if (index_rise)
        rev_cnt_ff <= rev_cnt_ff + 16'h0001; // [RULE_08]
    end
  end

  // sticky events: set wins over the clearing read
  logic [ev_count-1:0] ev_set;
  assign ev_set[ev_fault]  = fault_rise; // [RULE_07]
  assign ev_set[ev_index]  = index_rise; // [RULE_08]
  assign ev_set[ev_ready]  = ready_s != ready_d_ff;
  assign ev_set[ev_cmd]    = hs_done && !dir_ff;
  assign ev_set[ev_rsp]    = hs_done && dir_ff;
  assign ev_set[ev_parity] = hs_done && dir_ff && hs_perr; // [RULE_11]
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      event_ff <= '0;
      mask_ff  <= '0;
    end
    else
    begin
      event_ff <= (rd_event ? '0 : event_ff) | ev_set;
      if (wr_mask)
        mask_ff <= reg_wdata[ev_count-1:0];
    end
  end
  assign irq = |(event_ff & mask_ff);

  // read data, one cycle after the strobe
  wire [15:0] status_word = {10'h000, hs_busy, busy_d_ff, index_s,
                             ready_s, fault_s, write_gate};
  logic [15:0] rd_mux;
  always_comb
  begin
    unique case (reg_addr)
      reg_ctrl:   rd_mux = ctrl_ff;
      reg_cmd:    rd_mux = cmd_ff;
      reg_status: rd_mux = status_word;
      reg_event:  rd_mux = {{(16-ev_count){1'b0}}, event_ff};
      reg_mask:   rd_mux = {{(16-ev_count){1'b0}}, mask_ff};
      reg_resp:   rd_mux = hs_rsp;
      reg_index:  rd_mux = rev_cnt_ff;
      default:    rd_mux = 16'h0000;
    endcase
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= '0;
    else if (reg_read)
      rdata_ff <= rd_mux;
    else
      rdata_ff <= '0;
  end
  assign reg_rdata = rdata_ff;

  // cable outputs; shared by all drives, so the select code names the target
  drive_pins_t pins;
  assign pins.head_sel         = ctrl_ff[ctrl_head_lo +: 4]; // [RULE_03]
  assign pins.drive_sel        = ctrl_ff[ctrl_drive_lo +: 3]; // [RULE_04] [RULE_02]
  assign pins.write_gate       = ctrl_ff[ctrl_wr_bit] && !fault_s && ready_s; // [RULE_05]
  assign pins.read_gate        = ctrl_ff[ctrl_rd_bit] && !ctrl_ff[ctrl_wr_bit]; // [RULE_06]
  assign pins.transfer_request = hs_req; // [RULE_12]
  assign pins.command_out      = hs_data;

  assign head_sel_bit0       = pins.head_sel[0];
  assign head_sel_bit1       = pins.head_sel[1];
  assign head_sel_bit2       = pins.head_sel[2];
  assign head_sel_bit3       = pins.head_sel[3];
  assign drive_sel_code_bit1 = pins.drive_sel[0];
  assign drive_sel_code_bit2 = pins.drive_sel[1];
  assign drive_sel_code_bit3 = pins.drive_sel[2];
  assign write_gate          = pins.write_gate;
  assign read_gate           = pins.read_gate;
  assign transfer_request    = pins.transfer_request;
  assign command_out         = pins.command_out;
endmodule : drive_ctrl

// >>> tb/drive_ctrl_assertions.sv
// concurrent checks on the drive control block ports
`timescale 1ns/1ps
module drive_ctrl_assertions
  import drive_ctrl_pkg::*;
(
  // watched ports
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic        irq,
  input wire logic        head_sel_bit0,
  input wire logic        drive_sel_code_bit1,
  input wire logic        write_gate,
  input wire logic        read_gate,
  input wire logic        transfer_request,
  input wire logic        command_out,
  input wire logic        transfer_acknowledge,
  input wire logic        drive_fault_attention,
  input wire logic        drive_ready_in
);
  logic ctrl_wr;
  assign ctrl_wr = reg_write && reg_addr == reg_ctrl;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside answer cycle");
  a_wg_fault: assert property (drive_fault_attention [*3] |-> !write_gate)
    else $error("write gate stays up under fault");
  a_wg_ready: assert property (!drive_ready_in [*3] |-> !write_gate)
    else $error("write gate up while drive not ready");
  a_gates_excl: assert property (!(read_gate && write_gate))
    else $error("read gate and write gate together");
  a_req_hold: assert property (transfer_request && !transfer_acknowledge |=> transfer_request)
    else $error("request dropped before acknowledge");
  a_req_release: assert property ($fell(transfer_request) |-> $past(transfer_acknowledge, 2))
    else $error("request fell without acknowledge");
  a_cmd_stable: assert property (transfer_request && $past(transfer_request) |-> $stable(command_out))
    else $error("command bit moved while request high");
  a_irq_clear: assert property ($fell(irq) |->
    $past(reg_read && reg_addr == reg_event) || $past(reg_write && reg_addr == reg_mask))
    else $error("interrupt fell without event read or mask write");
  a_pins_written: assert property (!$stable({head_sel_bit0, drive_sel_code_bit1}) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("select pins moved without control write");
  c_irq_fell: cover property ($fell(irq));
  c_req_rose: cover property ($rose(transfer_request));
  c_wg_pulse: cover property (write_gate ##1 !write_gate);
endmodule : drive_ctrl_assertions
bind drive_ctrl drive_ctrl_assertions u_chk (
  .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq), .head_sel_bit0(head_sel_bit0),
  .drive_sel_code_bit1(drive_sel_code_bit1), .write_gate(write_gate),
  .read_gate(read_gate), .transfer_request(transfer_request), .command_out(command_out),
  .transfer_acknowledge(transfer_acknowledge), .drive_fault_attention(drive_fault_attention),
  .drive_ready_in(drive_ready_in)
);

// >>> tb/drive_model.sv
// behavioural drive answering the four-phase serial handshake
`timescale 1ns/1ps
module drive_model (
  // bench settings
  input  wire logic        clock,
  input  wire logic [3:0]  ack_dly,
  input  wire logic        load,
  input  wire logic [16:0] rsp_bits,
  // cable
  input  wire logic        transfer_request,
  input  wire logic        command_out,
  output logic             transfer_acknowledge,
  output logic             config_status_serial_in,
  output logic [16:0]      cmd_seen
);
  logic [3:0]  cnt_ff = 4'h0;
  logic [16:0] sh_ff = 17'h0_0000;
  initial
  begin
    transfer_acknowledge = 1'b0;
    config_status_serial_in = 1'b0;
    cmd_seen = 17'h0_0000;
  end
  // ack_dly of at least 1 puts the data bit out before acknowledge
  always @(posedge clock)
  begin
    if (load)
      sh_ff <= rsp_bits;
    if (transfer_request != transfer_acknowledge)
    begin
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff == 4'h0 && transfer_request)
        config_status_serial_in <= sh_ff[0];
      if (cnt_ff == ack_dly)
      begin
        cnt_ff <= 4'h0;
        transfer_acknowledge <= transfer_request;
        if (transfer_request)
        begin
          sh_ff <= sh_ff >> 1;
          cmd_seen <= {command_out, cmd_seen[16:1]};
        end
        else
          config_status_serial_in <= ~config_status_serial_in;
      end
    end
  end
endmodule : drive_model

// >>> tb/drive_ctrl_tb_top.sv
// self-checking bench for the serial drive control block
`timescale 1ns/1ps
module drive_ctrl_tb_top;
  import drive_ctrl_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic        irq, write_gate, read_gate, transfer_request, command_out, ack, csi;
  logic [3:0]  hs;
  logic [2:0]  ds;
  logic        fault = 1'b0;
  logic        ready = 1'b0;
  logic        index = 1'b0;
  logic [3:0]  ack_dly = 4'h2;
  logic        load = 1'b0;
  logic [16:0] rsp_bits = 17'h0_0000;
  logic [16:0] cmd_seen;
  logic [15:0] v;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  always #10 clock = ~clock;
  drive_ctrl uut (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .head_sel_bit0(hs[0]), .head_sel_bit1(hs[1]), .head_sel_bit2(hs[2]),
    .head_sel_bit3(hs[3]), .drive_sel_code_bit1(ds[0]), .drive_sel_code_bit2(ds[1]),
    .drive_sel_code_bit3(ds[2]), .write_gate(write_gate), .read_gate(read_gate),
    .transfer_request(transfer_request), .command_out(command_out),
    .config_status_serial_in(csi), .transfer_acknowledge(ack),
    .drive_fault_attention(fault), .drive_ready_in(ready), .index_pulse(index)
  );
  drive_model drv (
    .clock(clock), .ack_dly(ack_dly), .load(load), .rsp_bits(rsp_bits),
    .transfer_request(transfer_request), .command_out(command_out),
    .transfer_acknowledge(ack), .config_status_serial_in(csi), .cmd_seen(cmd_seen)
  );
  task automatic chk(input string n, input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic rc(input string n, input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(n, 17'(d), 17'(e));
  endtask : rc
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  task automatic wait_irq;
    for (int i = 0; i < 2000 && irq !== 1'b1; i++)
      @(posedge clock);
    #1 chk("irq", 17'(irq), 17'h1);
  endtask : wait_irq
  task automatic t_reset;
    chk("pins", 17'({hs, ds, write_gate, read_gate, transfer_request}), 17'h0);
    wr(4'hF, 16'hFFFF);
    rc("unmapped", 4'hF, 16'h0000);
    rc("ctrl", reg_ctrl, 16'h0000);
  endtask : t_reset
  task automatic t_select;
    for (int i = 0; i < 16; i++)
    begin
      wr(reg_ctrl, 16'(i) | (16'(i % 8) << 4));
      settle(2);
      chk("selects", 17'({hs, ds}), 17'({4'(i), 3'(i % 8)}));
    end
  endtask : t_select
  task automatic t_gates;
    wr(reg_mask, 16'h0001);
    ready <= 1'b1;
    wr(reg_ctrl, 16'h0300);
    settle(4);
    chk("gates rw", 17'({write_gate, read_gate}), 17'h2);
    wr(reg_ctrl, 16'h0200);
    settle(2);
    chk("gates r", 17'({write_gate, read_gate}), 17'h1);
    wr(reg_ctrl, 16'h0100);
    fault <= 1'b1;
    wait_irq;
    chk("wg fault", 17'(write_gate), 17'h0);
    rc("status", reg_status, 16'h0006);
    rc("event", reg_event, 16'h0005);
    chk("irq clear", 17'(irq), 17'h0);
    fault <= 1'b0;
    settle(4);
    chk("wg sticky", 17'(write_gate), 17'h0);
    ready <= 1'b0;
    wr(reg_ctrl, 16'h0100);
    settle(4);
    chk("wg not ready", 17'(write_gate), 17'h0);
    ready <= 1'b1;
    settle(4);
    chk("wg ready", 17'(write_gate), 17'h1);
  endtask : t_gates
  task automatic t_command;
    logic [15:0] c;
    wr(reg_ctrl, 16'h0000);
    wr(reg_mask, 16'h0008);
    rd(reg_event, v);
    for (int k = 0; k < 2; k++)
    begin
      c = k ? 16'h0001 : 16'hA5C3;
      ack_dly <= k ? 4'h9 : 4'h2;
      wr(reg_cmd, c);
      wr(reg_cmd, 16'hFFFF);
      wait_irq;
      chk("cmd", cmd_seen, {~^c, c});
      rc("event", reg_event, 16'h0008);
    end
  endtask : t_command
  task automatic t_resp;
    // length field counts data bits only; the parity bit follows them
    wr(reg_ctrl, 16'h2000);
    wr(reg_mask, 16'h0010);
    for (int k = 0; k < 2; k++)
    begin
      rsp_bits <= k ? 17'h0_005A : 17'h0_015A;
      load <= 1'b1;
      @(posedge clock);
      load <= 1'b0;
      wr(reg_index, 16'h0001);
      wait_irq;
      rd(reg_resp, v);
      chk("resp", 17'(v), 17'h0_5A00);
      rd(reg_event, v);
      chk("resp event", 17'(v[5:4]), 17'({1'(k), 1'b1}));
    end
  endtask : t_resp
  task automatic t_index;
    wr(reg_index, 16'h0000);
    wr(reg_mask, 16'h0002);
    for (int k = 0; k < 3; k++)
    begin
      index <= 1'b1;
      settle(4);
      index <= 1'b0;
      settle(4);
    end
    wait_irq;
    rc("revs", reg_index, 16'h0003);
    rc("event", reg_event, 16'h0002);
  endtask : t_index
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    settle(3);
    t_reset;
    t_select;
    t_gates;
    t_command;
    t_resp;
    t_index;
    complete_run;
  end
  initial
  begin
    #600000;
    n_mismatch++;
    complete_run;
  end
endmodule : drive_ctrl_tb_top
